// *** src/ocm_top.sv ***
// Purpose: mode decode and pin drive of one output compare channel
// Assumes: timer_tick_in marks each cycle in which the timer count is new
// Notes: a mode change re-initialises the pin and sequence
`timescale 1ns/1ps
// Summary of operation
// - mode comes from the lowest three bits of control word one
// - mode zero keeps the channel idle with no compare events
// - mode 001 starts low and goes high once on primary match
// - mode 010 starts high and goes low once on primary match
// - mode 011 toggles the pin on every primary match
// - mode 100 starts low, toggles on primary then secondary match, once
// - mode 101 starts low, toggles on alternating primary and secondary matches
// - mode 110 raises at count zero and lowers on primary match
// - mode 111 raises on primary match and lowers on secondary match
// - compare writes are buffered only in pwm modes, direct otherwise
module ocm_top
  import ocm_pkg::*;
(
  input wire logic clk_in,                                    // 200 MHz clock
  input wire logic arst_n_in,                                 // async reset, active low
  input wire logic [ocm_pkg::CTRL_W-1:0] compare_control_one_in, // control word one
  input wire logic [ocm_pkg::CMP_W-1:0] compare_timer_count_in,  // timebase count
  input wire logic timer_tick_in,                             // count advanced this cycle
  input wire logic primary_wr_in,                             // primary value write strobe
  input wire logic [ocm_pkg::CMP_W-1:0] primary_compare_value_in, // primary write data
  input wire logic secondary_wr_in,                           // secondary value write strobe
  input wire logic [ocm_pkg::CMP_W-1:0] secondary_compare_value_in, // secondary write data
  output logic compare_output_pin_out,                        // compare pin
  output logic channel_active_out                             // channel enabled
);
  import ocm_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  ocm_cmp_if pri_bus ();
  ocm_cmp_if sec_bus ();

  logic [MODE_W-1:0] mode_r;
  logic out_r;
  logic out_nxt;
  ocm_state_t st_r;
  ocm_state_t st_nxt;
  wire [MODE_W-1:0] mode_sel = compare_control_one_in[MODE_LSB +: MODE_W];
  wire mode_new = (mode_sel != mode_r);
  wire is_pwm = (mode_sel == MODE_PWM_EDGE) || (mode_sel == MODE_PWM_CENTRE);
  wire at_zero = (compare_timer_count_in == TMR_ZERO);
  wire boundary = timer_tick_in && at_zero;
  wire pri_hit = timer_tick_in && pri_bus.match;
  wire sec_hit = timer_tick_in && sec_bus.match;

  assign pri_bus.wr = primary_wr_in;
  assign pri_bus.wdata = primary_compare_value_in;
  assign pri_bus.pwm = is_pwm;
  assign pri_bus.load = boundary;
  assign pri_bus.count = compare_timer_count_in;
  assign sec_bus.wr = secondary_wr_in;
  assign sec_bus.wdata = secondary_compare_value_in;
  assign sec_bus.pwm = is_pwm;
  assign sec_bus.load = boundary;
  assign sec_bus.count = compare_timer_count_in;

  ocm_cmp_slot u_pri (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .cmp_bus(pri_bus)
  );

  ocm_cmp_slot u_sec (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .cmp_bus(sec_bus)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // a mode change wins over any match in the same cycle
  always_comb begin
    out_nxt = out_r;
    st_nxt = st_r;
    if (mode_sel == MODE_OFF) begin
      out_nxt = OUT_RST;
      st_nxt = OCM_ST_IDLE;
    end else if (mode_new) begin
      out_nxt = (mode_sel == MODE_SS_LOW);
      st_nxt = OCM_ST_WAIT_PRI;
    end else begin
      unique case (mode_sel)
        MODE_SS_HIGH, MODE_SS_LOW: begin
          if ((st_r == OCM_ST_WAIT_PRI) && pri_hit) begin
            out_nxt = (mode_sel == MODE_SS_HIGH);
            st_nxt = OCM_ST_DONE;
          end
        end
        MODE_TOGGLE: begin
          if (pri_hit) begin
            out_nxt = !out_r;
          end
        end
        MODE_DUAL_ONE, MODE_DUAL_CONT: begin
          if ((st_r == OCM_ST_WAIT_PRI) && pri_hit) begin
            out_nxt = !out_r;
            st_nxt = OCM_ST_WAIT_SEC;
          end else if ((st_r == OCM_ST_WAIT_SEC) && sec_hit) begin
            out_nxt = !out_r;
            st_nxt = (mode_sel == MODE_DUAL_ONE) ? OCM_ST_DONE : OCM_ST_WAIT_PRI;
          end
        end
        MODE_PWM_EDGE: begin
          // a zero duty value keeps the pin low, so the lower wins
          if (pri_hit) begin
            out_nxt = 1'b0;
          end else if (boundary) begin
            out_nxt = 1'b1;
          end
        end
        MODE_PWM_CENTRE: begin
          if (sec_hit) begin
            out_nxt = 1'b0;
          end else if (pri_hit) begin
            out_nxt = 1'b1;
          end
        end
        default: begin
          out_nxt = OUT_RST;
          st_nxt = OCM_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_r <= MODE_RST;
      out_r <= OUT_RST;
      st_r <= OCM_ST_IDLE;
    end else begin
      mode_r <= mode_sel;
      out_r <= out_nxt;
      st_r <= st_nxt;
    end
  end

  assign compare_output_pin_out = out_r;
  assign channel_active_out = (mode_r != MODE_OFF);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire hold = !mode_new;

  property p_off;
    @(posedge clk_in) disable iff (!arst_n_in)
    (mode_sel == MODE_OFF) |=> !out_r && (st_r == OCM_ST_IDLE) && !channel_active_out;
  endproperty
  a_off: assert property (p_off) else $error("disabled channel drove pin");

  property p_ss_high;
    @(posedge clk_in) disable iff (!arst_n_in)
    (mode_new && mode_sel == MODE_SS_HIGH) |=> !out_r && (st_r == OCM_ST_WAIT_PRI);
  endproperty
  a_ss_high: assert property (p_ss_high) else $error("single shot high did not start low");

  property p_ss_high_fire;
    @(posedge clk_in) disable iff (!arst_n_in)
    (hold && mode_sel == MODE_SS_HIGH && st_r == OCM_ST_WAIT_PRI && pri_hit) |=>
      out_r && (st_r == OCM_ST_DONE);
  endproperty
  a_ss_high_fire: assert property (p_ss_high_fire) else $error("single shot high did not fire");

  property p_ss_low;
    @(posedge clk_in) disable iff (!arst_n_in)
    (hold && mode_sel == MODE_SS_LOW && st_r == OCM_ST_WAIT_PRI && pri_hit) |=>
      !out_r && (st_r == OCM_ST_DONE) ##1 (hold && mode_sel == MODE_SS_LOW) [*1] |=> !out_r;
  endproperty
  a_ss_low: assert property (p_ss_low) else $error("single shot low failed");

  property p_toggle;
    @(posedge clk_in) disable iff (!arst_n_in)
    (hold && mode_sel == MODE_TOGGLE && pri_hit) |=> (out_r != $past(out_r));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle mode missed a match");

  property p_dual_one;
    @(posedge clk_in) disable iff (!arst_n_in)
    (hold && mode_sel == MODE_DUAL_ONE && st_r == OCM_ST_DONE) |=> $stable(out_r);
  endproperty
  a_dual_one: assert property (p_dual_one) else $error("single pulse repeated");

  property p_dual_cont;
    @(posedge clk_in) disable iff (!arst_n_in)
    (hold && mode_sel == MODE_DUAL_CONT && st_r == OCM_ST_WAIT_SEC && sec_hit) |=>
      (st_r == OCM_ST_WAIT_PRI) && (out_r != $past(out_r));
  endproperty
  a_dual_cont: assert property (p_dual_cont) else $error("pulse train did not rearm");

  property p_pwm_edge;
    @(posedge clk_in) disable iff (!arst_n_in)
    (hold && mode_sel == MODE_PWM_EDGE && boundary && !pri_hit) |=> out_r;
  endproperty
  a_pwm_edge: assert property (p_pwm_edge) else $error("edge pwm not raised at zero");

  property p_pwm_centre;
    @(posedge clk_in) disable iff (!arst_n_in)
    (hold && mode_sel == MODE_PWM_CENTRE && sec_hit) |=> !out_r;
  endproperty
  a_pwm_centre: assert property (p_pwm_centre) else $error("centre pwm not lowered");

  property p_buffered;
    @(posedge clk_in) disable iff (!arst_n_in)
    (is_pwm && primary_wr_in && !boundary) |=> $stable(pri_bus.active);
  endproperty
  a_buffered: assert property (p_buffered) else $error("pwm write bypassed buffer");

  property p_direct;
    @(posedge clk_in) disable iff (!arst_n_in)
    (!is_pwm && secondary_wr_in) |=> (sec_bus.active == $past(secondary_compare_value_in));
  endproperty
  a_direct: assert property (p_direct) else $error("direct write did not land");

  property p_load;
    @(posedge clk_in) disable iff (!arst_n_in)
    (is_pwm && boundary) |=> (pri_bus.active == $past(pri_bus.buffered))
      && (sec_bus.active == $past(sec_bus.buffered));
  endproperty
  a_load: assert property (p_load) else $error("boundary load missed");

  c_toggle: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    hold && mode_sel == MODE_TOGGLE && pri_hit);
  c_pulse_done: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    hold && mode_sel == MODE_DUAL_ONE && st_r == OCM_ST_DONE);
  c_edge_pwm: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    hold && mode_sel == MODE_PWM_EDGE && boundary ##[1:100] pri_hit);
  c_centre_load: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    mode_sel == MODE_PWM_CENTRE && boundary && primary_wr_in);
endmodule

// *** src/ocm_pkg.sv ***
// Purpose: shared constants and types of the output compare channel
// Assumes: 16-bit timer count and compare values
// Notes: mode codes follow the 3-bit mode field of the first control word
package ocm_pkg;
  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int CMP_W = 16;
  localparam int CTRL_W = 16;
  localparam int MODE_W = 3;
  localparam int MODE_LSB = 0;

  // ----------------------------------------------------------------
  // mode codes
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
  localparam logic [MODE_W-1:0] MODE_SS_HIGH = 3'h1;
  localparam logic [MODE_W-1:0] MODE_SS_LOW = 3'h2;
  localparam logic [MODE_W-1:0] MODE_TOGGLE = 3'h3;
  localparam logic [MODE_W-1:0] MODE_DUAL_ONE = 3'h4;
  localparam logic [MODE_W-1:0] MODE_DUAL_CONT = 3'h5;
  localparam logic [MODE_W-1:0] MODE_PWM_EDGE = 3'h6;
  localparam logic [MODE_W-1:0] MODE_PWM_CENTRE = 3'h7;

  // ----------------------------------------------------------------
  // reset values and timebase
  // ----------------------------------------------------------------
  localparam logic [CMP_W-1:0] CMP_RST = 16'h0000;
  localparam logic [CMP_W-1:0] TMR_ZERO = 16'h0000;
  localparam logic OUT_RST = 1'b0;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;

  // ----------------------------------------------------------------
  // sequencing state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OCM_ST_IDLE = 4'h1,
    OCM_ST_WAIT_PRI = 4'h2,
    OCM_ST_WAIT_SEC = 4'h4,
    OCM_ST_DONE = 4'h8
  } ocm_state_t;
endpackage

// *** src/ocm_cmp_if.sv ***
// Purpose: link between the channel control and one comparator slot
// Assumes: one clock domain
// Notes: ctrl drives writes and loads, slot answers with its active value
`timescale 1ns/1ps
interface ocm_cmp_if;
  import ocm_pkg::*;
  logic wr;
  logic [CMP_W-1:0] wdata;
  logic pwm;
  logic load;
  logic [CMP_W-1:0] count;
  logic [CMP_W-1:0] active;
  logic [CMP_W-1:0] buffered;
  logic match;
  modport ctrl (output wr, wdata, pwm, load, count, input active, buffered, match);
  modport slot (input wr, wdata, pwm, load, count, output active, buffered, match);
endinterface

// *** src/ocm_cmp_slot.sv ***
// Purpose: one compare value with its write buffer and comparator
// Assumes: load is a one-cycle pulse at the period boundary
// Notes: outside pwm a write reaches the comparator at once
`timescale 1ns/1ps
module ocm_cmp_slot
  import ocm_pkg::*;
(
  input wire logic clk_in,    // channel clock
  input wire logic arst_n_in, // async reset, active low
  ocm_cmp_if.slot cmp_bus     // control side
);
  logic [CMP_W-1:0] buf_r;
  logic [CMP_W-1:0] act_r;
  logic [CMP_W-1:0] act_nxt;
  logic [CMP_W-1:0] buf_nxt;

  // ----------------------------------------------------------------
  // buffer and active value
  // ----------------------------------------------------------------
  // the load copies the old buffer so a write in the boundary cycle waits a period
  assign buf_nxt = cmp_bus.wr ? cmp_bus.wdata : buf_r;
  assign act_nxt = (!cmp_bus.pwm && cmp_bus.wr) ? cmp_bus.wdata :
                   (cmp_bus.pwm && cmp_bus.load) ? buf_r : act_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      buf_r <= CMP_RST;
      act_r <= CMP_RST;
    end else begin
      buf_r <= buf_nxt;
      act_r <= act_nxt;
    end
  end

  assign cmp_bus.active = act_r;
  assign cmp_bus.buffered = buf_r;
  assign cmp_bus.match = (cmp_bus.count == act_r);
endmodule

// *** verification/ocm_pin_load.sv ***
// Purpose: load on the compare pin, counts rising edges
// Assumes: pin is a plain push-pull output
// Notes: passive, never drives the channel back
`timescale 1ns/1ps
module ocm_pin_load (
  input wire logic clk_in,     // channel clock
  input wire logic arst_n_in,  // async reset, active low
  input wire logic pin_in,     // compare pin
  output logic [7:0] rises_out // rising edges seen
);
  logic pin_r;
  // ----------------------------------------------------------------
  // edge counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_r <= 1'b0;
      rises_out <= 8'h00;
    end else begin
      pin_r <= pin_in;
      if (pin_in && !pin_r) begin
        rises_out <= rises_out + 8'h01;
      end
    end
  end
endmodule

// *** verification/test_output_compare_mode_logic.sv ***
// Purpose: self-checking bench of the output compare channel
// Assumes: the pin settles within three cycles of its cause
// Notes: sweeps in pwm modes pass count zero only where a buffer load is meant
`timescale 1ns/1ps
module test_output_compare_mode_logic;
  import ocm_pkg::*;
  logic clk_in;
  logic arst_n_in;
  logic [CTRL_W-1:0] ctrl;
  logic [CMP_W-1:0] cnt;
  logic tick;
  logic pri_wr;
  logic [CMP_W-1:0] pri_val;
  logic sec_wr;
  logic [CMP_W-1:0] sec_val;
  logic pin;
  logic active;
  logic [7:0] rises;
  int num_errors = 0;
  int samples_checked = 0;

  ocm_top i_ocm_top (.clk_in(clk_in), .arst_n_in(arst_n_in), .compare_control_one_in(ctrl),
    .compare_timer_count_in(cnt), .timer_tick_in(tick), .primary_wr_in(pri_wr),
    .primary_compare_value_in(pri_val), .secondary_wr_in(sec_wr),
    .secondary_compare_value_in(sec_val), .compare_output_pin_out(pin), .channel_active_out(active));
  ocm_pin_load i_ocm_pin_load (.clk_in(clk_in), .arst_n_in(arst_n_in), .pin_in(pin), .rises_out(rises));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic set_mode(input logic [MODE_W-1:0] m, input logic [12:0] upper);
    @(posedge clk_in);
    ctrl <= {upper, m};
    tick <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic pe, input logic [15:0] p, input logic se, input logic [15:0] s);
    @(posedge clk_in);
    pri_wr <= pe;
    pri_val <= p;
    sec_wr <= se;
    sec_val <= s;
    @(posedge clk_in);
    pri_wr <= 1'b0;
    sec_wr <= 1'b0;
  endtask
  // tick only while sweeping, so held counts never match twice
  task automatic sweep(input int lo, input int hi);
    for (int c = lo; c <= hi; c++) begin
      @(posedge clk_in);
      cnt <= c[15:0];
      tick <= 1'b1;
    end
    @(posedge clk_in);
    tick <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_off;
    wr(1'b1, 16'h0005, 1'b1, 16'h0009);
    set_mode(MODE_OFF, 13'h1FFF);
    sweep(0, 10);
    chk("pin", 16'h0000, {15'h0000, pin});
    chk("active", 16'h0000, {15'h0000, active});
    chk("rises", 16'h0000, {8'h00, rises});
  endtask
  task automatic t_single_high;
    set_mode(MODE_SS_HIGH, 13'h1555);
    chk("active", 16'h0001, {15'h0000, active});
    chk("pin", 16'h0000, {15'h0000, pin});
    sweep(0, 6);
    chk("pin", 16'h0001, {15'h0000, pin});
  endtask
  task automatic t_single_low;
    set_mode(MODE_SS_LOW, 13'h0000);
    chk("pin", 16'h0001, {15'h0000, pin});
    for (int i = 0; i < 2; i++) begin
      sweep(0, 6);
      chk("pin", 16'h0000, {15'h0000, pin});
    end
  endtask
  task automatic t_toggle;
    logic [7:0] r0;
    set_mode(MODE_TOGGLE, 13'h0000);
    r0 = rises;
    sweep(0, 6);
    chk("pin", 16'h0001, {15'h0000, pin});
    sweep(0, 6);
    chk("pin", 16'h0000, {15'h0000, pin});
    wr(1'b1, 16'h0002, 1'b0, 16'h0000);
    sweep(0, 2);
    chk("pin", 16'h0001, {15'h0000, pin});
    chk("rises", {8'h00, r0 + 8'h02}, {8'h00, rises});
  endtask
  task automatic t_dual(input logic [MODE_W-1:0] m, input logic rearm);
    wr(1'b1, 16'h0003, 1'b1, 16'h0006);
    set_mode(m, 13'h0000);
    chk("pin", 16'h0000, {15'h0000, pin});
    for (int i = 0; i < 2; i++) begin
      sweep(0, 4);
      chk("pin", {15'h0000, rearm || i == 0}, {15'h0000, pin});
      sweep(5, 8);
      chk("pin", 16'h0000, {15'h0000, pin});
    end
  endtask
  task automatic t_pwm_edge;
    set_mode(MODE_PWM_EDGE, 13'h0000);
    wr(1'b1, 16'h0004, 1'b0, 16'h0000);
    sweep(0, 2);
    chk("pin", 16'h0001, {15'h0000, pin});
    sweep(3, 5);
    chk("pin", 16'h0000, {15'h0000, pin});
    sweep(0, 2);
    wr(1'b1, 16'h0008, 1'b0, 16'h0000);
    sweep(3, 5);
    chk("pin", 16'h0000, {15'h0000, pin});
    sweep(0, 6);
    chk("pin", 16'h0001, {15'h0000, pin});
    sweep(7, 9);
    chk("pin", 16'h0000, {15'h0000, pin});
  endtask
  task automatic t_pwm_centre;
    set_mode(MODE_OFF, 13'h0000);
    wr(1'b1, 16'h0003, 1'b1, 16'h0007);
    set_mode(MODE_PWM_CENTRE, 13'h0000);
    sweep(1, 4);
    chk("pin", 16'h0001, {15'h0000, pin});
    sweep(5, 8);
    chk("pin", 16'h0000, {15'h0000, pin});
    // a write in the boundary cycle must wait for the next boundary
    @(posedge clk_in);
    cnt <= 16'h0000;
    tick <= 1'b1;
    pri_wr <= 1'b1;
    pri_val <= 16'h0005;
    @(posedge clk_in);
    tick <= 1'b0;
    pri_wr <= 1'b0;
    sweep(1, 4);
    chk("pin", 16'h0001, {15'h0000, pin});
    sweep(5, 8);
    chk("pin", 16'h0000, {15'h0000, pin});
    sweep(0, 6);
    chk("pin", 16'h0001, {15'h0000, pin});
    sweep(7, 8);
    chk("pin", 16'h0000, {15'h0000, pin});
  endtask

  // ----------------------------------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    arst_n_in = 1'b0;
    ctrl = '0;
    cnt = '0;
    tick = 1'b0;
    pri_wr = 1'b0;
    pri_val = '0;
    sec_wr = 1'b0;
    sec_val = '0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_off();
    t_single_high();
    t_single_low();
    t_toggle();
    t_dual(MODE_DUAL_ONE, 1'b0);
    t_dual(MODE_DUAL_CONT, 1'b1);
    t_pwm_edge();
    t_pwm_centre();
    print_verdict();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    num_errors++;
    print_verdict();
  end
endmodule
